// File: wdt_cfg.svh
/*
  Constants for the I/O port watchdog: port address, field positions,
  reset values and timing counts.
  Assumes a 250 MHz system clock; included by its bare name.
*/
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// ********************************************************************
// Port decode
// ********************************************************************
`define WDT_ADDR_W          16
`define WDT_PORT_ADDR       16'h0443
`define WDT_DATA_W          8

// ********************************************************************
// Field layout of the written and read byte
// ********************************************************************
`define WDT_IVAL_LSB        0
`define WDT_IVAL_MSB        5
`define WDT_IVAL_W          6
`define WDT_RD_FIRED_BIT    6
`define WDT_RD_ARMED_BIT    7
`define WDT_IVAL_RST        6'h00
`define WDT_RDATA_RST       8'h00

// ********************************************************************
// Timing
// ********************************************************************
`define WDT_CLK_PERIOD_NS   4
`define WDT_TICK_NS         1000000000
`define WDT_TICK_CYCLES     (`WDT_TICK_NS / `WDT_CLK_PERIOD_NS)
`define WDT_RST_PULSE_NS    1000
`define WDT_RST_PULSE_CYC   (`WDT_RST_PULSE_NS / `WDT_CLK_PERIOD_NS)

`endif

// File: wdt_pkg.sv
/*
  Types shared by the watchdog files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package wdt_pkg;

  // Countdown sequencer, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_FIRE = 3'b100
  } wdt_state_t;

  // Expiry action selected by the static configuration input
  typedef enum logic {
    ACT_RESET = 1'b0,
    ACT_IRQ   = 1'b1
  } wdt_action_t;

endpackage

// File: wdt_tick_gen.sv
/*
  One-second time base for the watchdog, a restartable divider of the system clock.
  Assumes a restart pulse from the same clock domain.
*/
`timescale 1ns/10ps

module wdt_tick_gen #(
  parameter int unsigned CYCLES = 250000000
) (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_srst,
  // Control
  input  wire logic i_restart,
  // Tick out
  output logic      o_tick
);

  localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_tick;

  // Restart realigns the second so a fresh interval is never short
  always_comb begin
    next_count = count;
    next_tick  = 1'b0;
    if (i_restart) begin
      next_count = '0;
    end else if (count == LAST) begin
      next_count = '0;
      next_tick  = 1'b1;
    end else begin
      next_count = count + CW'(1);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      count  <= '0;
      o_tick <= 1'b0;
    end else begin
      count  <= next_count;
      o_tick <= next_tick;
    end
  end

endmodule

// File: wdt_io_port.sv
/*
  I/O port watchdog timer: one 8-bit port; a nonzero write loads and arms the
  interval, a read disarms, expiry pulses a CPU reset or raises an interrupt.
  Assumes single-cycle I/O strobes from logic on the system clock and a
  static action select that may come from a pin or jumper.
*/
// Contract
// - A write to port 443 hex loads the interval and, if it is nonzero, arms the countdown.
// - Timeout equals written value in seconds, one second per count.
// - Every nonzero-interval write outside a reset pulse and without a read in the same cycle restarts the countdown from the newly written interval.
// - A read of the port disarms; nothing fires until written again.
// - Unrefreshed expiry asserts CPU reset or raises an interrupt request.
`timescale 1ns/10ps
`include "wdt_cfg.svh"

module wdt_io_port #(
  parameter int unsigned TICK_CYCLES = `WDT_TICK_CYCLES,
  parameter int unsigned RST_CYCLES  = `WDT_RST_PULSE_CYC,
  parameter int unsigned ADDR_W      = `WDT_ADDR_W
) (
  // Clock and reset
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_srst,
  // I/O port access
  input  wire logic [ADDR_W-1:0]      i_io_addr,
  input  wire logic                   i_io_wr,
  input  wire logic                   i_io_rd,
  input  wire logic [`WDT_DATA_W-1:0] i_io_wdata,
  output logic      [`WDT_DATA_W-1:0] o_io_rdata,
  output logic                        o_io_rvalid,
  // Configuration
  input  wire logic                   i_act_irq,
  // Expiry actions and status
  output logic                        o_cpu_rst,
  output logic                        o_irq,
  output logic                        o_armed
);

  // ********************************************************************
  // Helpers
  // ********************************************************************
  localparam int unsigned RW = (RST_CYCLES > 1) ? $clog2(RST_CYCLES + 1) : 1;

  function automatic logic port_hit(input logic [ADDR_W-1:0] addr);
    port_hit = (addr == ADDR_W'(`WDT_PORT_ADDR));
  endfunction

  // ********************************************************************
  // Action select synchroniser
  // ********************************************************************
  logic act_meta;
  logic act_sync;

  // Only the second stage feeds logic; the first may still be settling
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      act_meta <= 1'b0;
      act_sync <= 1'b0;
    end else begin
      act_meta <= i_act_irq;
      act_sync <= act_meta;
    end
  end

  // ********************************************************************
  // Port decode
  // ********************************************************************
  logic wr_hit;
  logic rd_hit;

  // Strobes to any other address belong to other devices and are ignored
  // port decode
  assign wr_hit = i_io_wr && port_hit(i_io_addr);
  assign rd_hit = i_io_rd && port_hit(i_io_addr);

  // ********************************************************************
  // One-second time base
  // ********************************************************************
  logic tick;

  wdt_tick_gen #(
    .CYCLES (TICK_CYCLES)
  ) wdt_tick_gen_i (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_restart (wr_hit),
    .o_tick    (tick)
  );

  // ********************************************************************
  // Countdown sequencer
  // ********************************************************************
  wdt_pkg::wdt_state_t    state;
  wdt_pkg::wdt_state_t    next_state;
  logic [`WDT_IVAL_W-1:0] remain;
  logic [`WDT_IVAL_W-1:0] next_remain;
  logic [RW-1:0]          rst_cnt;
  logic [RW-1:0]          next_rst_cnt;
  logic                   fired;
  logic                   next_fired;
  logic                   next_cpu_rst;
  logic                   next_irq;
  logic                   next_armed;
  logic [`WDT_IVAL_W-1:0] wr_ival;

  assign wr_ival = i_io_wdata[`WDT_IVAL_MSB:`WDT_IVAL_LSB];

  always_comb begin
    next_state   = state;
    next_remain  = remain;
    next_rst_cnt = rst_cnt;
    next_fired   = fired;
    next_irq     = o_irq;
    next_cpu_rst = 1'b0;
    case (state)
      wdt_pkg::ST_IDLE: begin
        next_remain = remain;
      end
      wdt_pkg::ST_RUN: begin
        if (tick) begin
          if (remain == `WDT_IVAL_W'(1)) begin
            next_remain  = '0;
            next_state   = wdt_pkg::ST_FIRE;
            next_fired   = 1'b1;
            next_rst_cnt = RW'(RST_CYCLES);
          end else begin
            next_remain = remain - `WDT_IVAL_W'(1);
          end
        end
      end
      wdt_pkg::ST_FIRE: begin
        if (wdt_pkg::wdt_action_t'(act_sync) == wdt_pkg::ACT_IRQ) begin
          next_irq   = 1'b1;
          next_state = wdt_pkg::ST_IDLE;
        end else if (rst_cnt != '0) begin
          next_cpu_rst = 1'b1;
          next_rst_cnt = rst_cnt - RW'(1);
        end else begin
          next_state = wdt_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state  = wdt_pkg::ST_IDLE;
        next_remain = '0;
      end
    endcase
    // Port accesses win over the sequencer; a reset pulse in flight is finished
    if (state != wdt_pkg::ST_FIRE || next_state != wdt_pkg::ST_FIRE) begin
      if (rd_hit) begin
        next_state  = wdt_pkg::ST_IDLE;
        next_remain = '0;
        // An interrupt raised in this very cycle wins over the clear
        next_irq    = next_irq && !o_irq;
      end else if (wr_hit) begin
        next_remain = wr_ival;
        next_fired  = 1'b0;
        // As above: a fresh expiry is never lost to a refresh
        next_irq    = next_irq && !o_irq;
        // Zero is outside the legal range and leaves the timer stopped
        next_state  = (wr_ival != '0) ? wdt_pkg::ST_RUN : wdt_pkg::ST_IDLE;
      end
    end
    // Status follows the state being entered, so it moves with the access
    next_armed = (next_state == wdt_pkg::ST_RUN);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state     <= wdt_pkg::ST_IDLE;
      remain    <= `WDT_IVAL_RST;
      rst_cnt   <= '0;
      fired     <= 1'b0;
      o_irq     <= 1'b0;
      o_cpu_rst <= 1'b0;
      o_armed   <= 1'b0;
    end else begin
      state     <= next_state;
      remain    <= next_remain;
      rst_cnt   <= next_rst_cnt;
      fired     <= next_fired;
      o_irq     <= next_irq;
      o_cpu_rst <= next_cpu_rst;
      o_armed   <= next_armed;
    end
  end

  // ********************************************************************
  // Read data
  // ********************************************************************
  logic [`WDT_DATA_W-1:0] next_rdata;
  logic                   next_rvalid;

  // Snapshot before the read takes effect, so software sees what it stopped;
  // the bus reads zero outside the answer cycle so stale status never leaks
  always_comb begin
    next_rdata  = `WDT_RDATA_RST;
    next_rvalid = rd_hit;
    if (rd_hit) begin
      next_rdata[`WDT_IVAL_MSB:`WDT_IVAL_LSB] = remain;
      next_rdata[`WDT_RD_FIRED_BIT]           = fired;
      next_rdata[`WDT_RD_ARMED_BIT]           = (state == wdt_pkg::ST_RUN);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_io_rdata  <= `WDT_RDATA_RST;
      o_io_rvalid <= 1'b0;
    end else begin
      o_io_rdata  <= next_rdata;
      o_io_rvalid <= next_rvalid;
    end
  end

endmodule

// File: wdt_io_port_monitor.sv
/*
  Checker for the port watchdog, bound to its top module.
  Assumes the port is driven from the system clock domain.
*/
`timescale 1ns/10ps
`include "wdt_cfg.svh"

module wdt_io_port_monitor #(
  parameter int unsigned TICK_CYCLES = 20,
  parameter int unsigned RST_CYCLES  = 4,
  parameter int unsigned ADDR_W      = 16
) (
  // Clock and reset
  input wire logic              i_clk_sys,
  input wire logic              i_srst,
  // Port access
  input wire logic [ADDR_W-1:0] i_io_addr,
  input wire logic              i_io_wr,
  input wire logic              i_io_rd,
  input wire logic [7:0]        i_io_wdata,
  input wire logic [7:0]        o_io_rdata,
  input wire logic              o_io_rvalid,
  // Action and status
  input wire logic              i_act_irq,
  input wire logic              o_cpu_rst,
  input wire logic              o_irq,
  input wire logic              o_armed
);
  logic        wr_hit;
  logic        rd_hit;
  int unsigned since_wr;
  int unsigned rst_len;
  logic [5:0]  ival;

  assign wr_hit = i_io_wr && (i_io_addr == `WDT_PORT_ADDR);
  assign rd_hit = i_io_rd && (i_io_addr == `WDT_PORT_ADDR);

  // Cycles since the last access, so expiry time can be judged
  always_ff @(posedge i_clk_sys) begin
    since_wr <= (i_srst || wr_hit || rd_hit) ? 0 : since_wr + 1;
    rst_len  <= (i_srst || !o_cpu_rst) ? 0 : rst_len + 1;
    if (wr_hit) begin
      ival <= i_io_wdata[5:0];
    end
  end

  // ********************************************************************
  // Properties
  // ********************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  sequence expiry_s;
    $fell(o_armed) && !$past(wr_hit || rd_hit);
  endsequence

  a_write_arms: assert property (wr_hit && !rd_hit && i_io_wdata[5:0] != 6'h00
    |=> o_armed || o_cpu_rst) else $error("write did not arm");
  a_read_disarms: assert property (rd_hit |=> !o_armed && o_io_rvalid
    && (!o_irq || !$past(o_irq))) else $error("read did not disarm");
  a_timeout_span: assert property (expiry_s |-> since_wr + 1 >= ival * TICK_CYCLES
    && since_wr <= ival * TICK_CYCLES + 3) else $error("expiry at wrong time");
  a_fire_action: assert property (expiry_s |=> o_irq || o_cpu_rst)
    else $error("expiry without action");
  a_no_spurious: assert property ($rose(o_irq) || $rose(o_cpu_rst) |-> $past(o_armed, 2))
    else $error("action while disarmed");
  a_action_sel: assert property ($rose(o_irq || o_cpu_rst) |-> o_irq == i_act_irq)
    else $error("wrong expiry action");
  a_rst_len: assert property ($fell(o_cpu_rst) |-> rst_len == RST_CYCLES)
    else $error("reset pulse length wrong");
  a_rvalid_cause: assert property (o_io_rvalid |-> $past(rd_hit))
    else $error("read data without read");
endmodule

// File: wdt_io_port_tb.sv
/*
  Self-checking bench for the port watchdog.
  Assumes the checker file is compiled before this one.
*/
`timescale 1ns/10ps
`include "wdt_cfg.svh"

module wdt_io_port_tb;
  localparam int unsigned TICK = 20;
  logic        i_clk_sys  = 1'b0;
  logic        i_srst     = 1'b1;
  logic [15:0] i_io_addr  = 16'h0000;
  logic        i_io_wr    = 1'b0;
  logic        i_io_rd    = 1'b0;
  logic [7:0]  i_io_wdata = 8'h00;
  logic        i_act_irq  = 1'b0;
  logic [7:0]  o_io_rdata;
  logic        o_io_rvalid;
  logic        o_cpu_rst;
  logic        o_irq;
  logic        o_armed;
  int          mismatches  = 0;
  int          check_count = 0;

  always #2 i_clk_sys = ~i_clk_sys;

  wdt_io_port #(.TICK_CYCLES(TICK), .RST_CYCLES(4)) wdt_io_port_i (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_io_addr(i_io_addr), .i_io_wr(i_io_wr),
    .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
    .o_io_rvalid(o_io_rvalid), .i_act_irq(i_act_irq), .o_cpu_rst(o_cpu_rst),
    .o_irq(o_irq), .o_armed(o_armed));

  // ********************************************************************
  // Tasks
  // ********************************************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    i_io_addr  = a;
    i_io_wdata = d;
    i_io_wr    = 1'b1;
    @(negedge i_clk_sys);
    i_io_wr = 1'b0;
  endtask

  // Returns {valid, data} as seen one cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [8:0] r);
    @(negedge i_clk_sys);
    i_io_addr = a;
    i_io_rd   = 1'b1;
    @(negedge i_clk_sys);
    i_io_rd = 1'b0;
    r = {o_io_rvalid, o_io_rdata};
  endtask

  task automatic outs(input string what, input logic [2:0] exp);
    chk(what, {13'h0000, exp}, {13'h0000, o_armed, o_irq, o_cpu_rst});
  endtask

  // Bounded wait for the countdown to run out, from the end of a write
  task automatic expire(input int n);
    int c;
    c = 0;
    while (o_armed === 1'b1 && c < n * TICK + 10) begin
      @(negedge i_clk_sys);
      c++;
    end
    chk("span", 16'h0001, {15'h0000, c >= n * TICK - 1 && c <= n * TICK + 4});
    @(negedge i_clk_sys);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ********************************************************************
  // Tests
  // ********************************************************************
  initial begin
    logic [8:0] r;
    repeat (12) @(negedge i_clk_sys);
    i_srst = 1'b0;
    outs("reset outs", 3'b000);
    wr(16'h0442, 8'h05);
    rd(16'h0442, r);
    chk("foreign", 16'h0000, {7'h00, r});
    outs("foreign", 3'b000);
    wr(`WDT_PORT_ADDR, 8'hC2);
    outs("armed", 3'b100);
    rd(`WDT_PORT_ADDR, r);
    chk("snapshot", 16'h0182, {7'h00, r});
    repeat (3 * TICK) @(negedge i_clk_sys);
    outs("disarmed", 3'b000);
    i_act_irq = 1'b1;
    repeat (4) @(negedge i_clk_sys);
    wr(`WDT_PORT_ADDR, 8'h01);
    expire(1);
    outs("irq", 3'b010);
    rd(`WDT_PORT_ADDR, r);
    chk("fired", 16'h0005, {13'h0000, r[8:6]});
    outs("cleared", 3'b000);
    // Interval zero lies outside the legal range and must stop the count
    wr(`WDT_PORT_ADDR, 8'h05);
    outs("armed again", 3'b100);
    wr(`WDT_PORT_ADDR, 8'h00);
    outs("zero stops", 3'b000);
    wr(`WDT_PORT_ADDR, 8'h01);
    repeat (3) begin
      repeat (TICK - 6) @(negedge i_clk_sys);
      wr(`WDT_PORT_ADDR, 8'h01);
    end
    outs("refreshed", 3'b100);
    expire(1);
    rd(`WDT_PORT_ADDR, r);
    i_act_irq = 1'b0;
    repeat (4) @(negedge i_clk_sys);
    wr(`WDT_PORT_ADDR, 8'h3F);
    expire(63);
    outs("cpu reset", 3'b001);
    // A write in the middle of the reset pulse is ignored
    wr(`WDT_PORT_ADDR, 8'h01);
    outs("refused", 3'b001);
    repeat (8) @(negedge i_clk_sys);
    outs("after pulse", 3'b000);
    results();
  end

  initial begin
    #(4 * 6000);
    mismatches++;
    results();
  end
endmodule

bind wdt_io_port wdt_io_port_monitor #(.TICK_CYCLES(TICK_CYCLES), .RST_CYCLES(RST_CYCLES),
  .ADDR_W(ADDR_W)) wdt_io_port_monitor_i (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
  .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata),
  .o_io_rdata(o_io_rdata), .o_io_rvalid(o_io_rvalid), .i_act_irq(i_act_irq),
  .o_cpu_rst(o_cpu_rst), .o_irq(o_irq), .o_armed(o_armed));
